// ===== rtl/rtc_alarm_ctrl.sv
// rtc alarm matching, control register, interrupt and wave routing
//
// Function
// - alarm a all masked: every second
// - alarm a: seconds match only
// - alarm a: minutes, seconds match
// - alarm a: hours, minutes, seconds match
// - alarm a unmasked: full match
// - alarm b all masked: at seconds 00
// - alarm b: minutes match
// - alarm b: hours and minutes match
// - alarm b unmasked: full match
// - bit 7 stops oscillator, resets 0
// - rate select picks wave rate
// - rate resets to highest
// - routing 1: alarm b to shared pin
// - routing 0: wave on shared pin, resets 0
// - alarm b enable gates its interrupt
// - alarm a enable gates alarm a on pin a
// - interrupt enables reset to 0
// - compare only on second update
// - bit 7 masks field, bit 6 selects day
// - flag cleared by writing 0 only
// - interrupt asserted low, idle when none
`timescale 1ns/10ps
module rtc_alarm_ctrl
  import rtc_pkg::*;
(
  input  wire logic       clk_i,               // register clock
  input  wire logic       rst_n_i,             // sync reset, low
  input  wire logic       ce_i,                // clock enable
  input  wire logic       osc_clk_i,           // oscillator clock
  input  wire logic       sec_tick_i,          // once-per-second update
  input  wire logic [6:0] cur_sec_i,           // current seconds
  input  wire logic [6:0] cur_min_i,           // current minutes
  input  wire logic [6:0] cur_hour_i,          // current hours
  input  wire logic [2:0] cur_day_i,           // current weekday
  input  wire logic [5:0] cur_date_i,          // current month day
  input  wire logic       reg_wr_i,            // register write strobe
  input  wire logic       reg_rd_i,            // register read strobe
  input  wire logic [4:0] reg_addr_i,          // register offset
  input  wire logic [7:0] reg_wdata_i,         // write data
  output logic      [7:0] reg_rdata_o,         // read data
  output logic            osc_enable_n_o,      // oscillator stop, high
  output logic            irq_out_a_n_o,       // first interrupt pin
  output logic            irq_out_a_oe_o,      // first pin drive
  output logic            wave_or_irq_b_out_o, // shared pin level
  output logic            wave_or_irq_b_oe_o   // shared pin drive
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]      alm_mem [ALARM_CNT]; // alarm storage
  logic [7:0]      ctl_reg;             // control register
  logic            fa_reg;              // alarm a flag
  logic            fb_reg;              // alarm b flag
  logic [7:0]      rdata_reg;           // read data
  logic            irq_a_n_reg;         // first pin level
  logic            irq_a_oe_reg;        // first pin drive
  logic            pin_b_reg;           // shared pin level
  logic            pin_b_oe_reg;        // shared pin drive
  logic [WV_W-1:0] ws1_reg;             // wave sync, first stage
  logic [WV_W-1:0] ws2_reg;             // wave sync, usable

  // register decode
  logic       alm_hit;   // offset in alarm range
  logic [2:0] alm_idx;   // alarm storage index
  logic       alm_wr;    // alarm write
  logic       ctl_wr;    // control write
  logic       st_wr;     // status write
  logic [7:0] ctl_next;  // control value to store
  logic [7:0] rd_mux;    // read selection
  logic [7:0] st_val;    // status read value

  // control fields
  logic       osc_en_n;  // oscillator stop request
  rtc_rate_t  rate;      // square-wave rate
  logic       route;     // interrupt routing
  logic       a_en;      // alarm a interrupt enable
  logic       b_en;      // alarm b interrupt enable

  // alarm a compare
  logic [7:0] a_sec;     // alarm a seconds entry
  logic [7:0] a_min;     // alarm a minutes entry
  logic [7:0] a_hour;    // alarm a hours entry
  logic [7:0] a_dd;      // alarm a day/date entry
  logic       a_sec_ok;  // seconds masked or equal
  logic       a_min_ok;  // minutes masked or equal
  logic       a_hr_ok;   // hours masked or equal
  logic       a_dd_eq;   // day or date equal
  logic       a_dd_ok;   // day/date masked or equal
  logic       a_match;   // alarm a match
  logic       a_set;     // alarm a flag set

  // alarm b compare
  logic [7:0] b_min;     // alarm b minutes entry
  logic [7:0] b_hour;    // alarm b hours entry
  logic [7:0] b_dd;      // alarm b day/date entry
  logic       sec_zero;  // seconds read 00
  logic       b_min_ok;  // minutes masked or equal
  logic       b_hr_ok;   // hours masked or equal
  logic       b_dd_eq;   // day or date equal
  logic       b_dd_ok;   // day/date masked or equal
  logic       b_match;   // alarm b match
  logic       b_set;     // alarm b flag set

  // flags and pins
  logic       fa_clr;    // alarm a clear by write
  logic       fb_clr;    // alarm b clear by write
  logic       fa_next;   // alarm a flag next
  logic       fb_next;   // alarm b flag next
  logic       irq_a_act; // first pin asserted
  logic       irq_b_act; // shared pin interrupt asserted
  logic       osc_wave;  // sampled oscillator, gated
  logic       wave_sel;  // selected square wave
  logic       pin_b_next;// shared pin next level

  rtc_wave_if wif ();    // carrier to the divider

  // ----------------------------------------------------------------
  // oscillator-domain divider
  // ----------------------------------------------------------------
  assign wif.run    = ~osc_en_n;
  assign wif.freeze = ~ce_i;

  rtc_wave_gen u_wave (
    .osc_clk_i (osc_clk_i),
    .rst_n_i   (rst_n_i),
    .wif       (wif)
  );

  // two-flop crossing of the taps and of the raw
  // oscillator; the fastest rate thus carries up to
  // one register period of jitter
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ws1_reg <= '0;
      ws2_reg <= '0;
    end
    else if (ce_i)
    begin
      ws1_reg <= {osc_clk_i, wif.wave};
      ws2_reg <= ws1_reg;
    end
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign alm_hit  = (reg_addr_i >= ADDR_A_SEC) && (reg_addr_i <= ADDR_B_DD);
  assign alm_idx  = 3'(reg_addr_i - ADDR_A_SEC);
  assign alm_wr   = reg_wr_i & alm_hit;
  assign ctl_wr   = reg_wr_i & (reg_addr_i == ADDR_CTRL);
  assign st_wr    = reg_wr_i & (reg_addr_i == ADDR_STATUS);
  assign ctl_next = reg_wdata_i & CTL_WMASK; // unused bits stay 0

  // status holds only the two alarm flags
  assign st_val = {6'h00, fb_reg, fa_reg};

  // unmapped offsets read as zero
  assign rd_mux = alm_hit                     ? alm_mem[alm_idx] :
                  (reg_addr_i == ADDR_CTRL)   ? ctl_reg          :
                  (reg_addr_i == ADDR_STATUS) ? st_val           :
                  8'h00;

  // ----------------------------------------------------------------
  // alarm storage, one entry per offset
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < ALARM_CNT; gi++)
  begin : g_alm
    // no defined power-up value, so cleared to keep sim clean
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
        alm_mem[gi] <= 8'h00;
      else if (ce_i && alm_wr && (alm_idx == 3'(gi)))
        alm_mem[gi] <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // reset: oscillator on, fastest wave on the shared pin,
  // alarm interrupts off
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      ctl_reg <= CTL_RESET;
    else if (ce_i && ctl_wr)
      ctl_reg <= ctl_next;
  end

  assign osc_en_n = ctl_reg[CTL_OSC_N_BIT];
  assign rate     = rtc_rate_t'(ctl_reg[CTL_RS_HI_BIT:CTL_RS_LO_BIT]);
  assign route    = ctl_reg[CTL_ROUTE_BIT];
  assign a_en     = ctl_reg[CTL_A_EN_BIT];
  assign b_en     = ctl_reg[CTL_B_EN_BIT];

  // ----------------------------------------------------------------
  // alarm a compare
  // ----------------------------------------------------------------
  assign a_sec  = alm_mem[IDX_A_SEC];
  assign a_min  = alm_mem[IDX_A_MIN];
  assign a_hour = alm_mem[IDX_A_HOUR];
  assign a_dd   = alm_mem[IDX_A_DD];

  // a set mask bit makes its field always agree
  assign a_sec_ok = a_sec[MASK_BIT] | (a_sec[TIME_W-1:0] == cur_sec_i);
  assign a_min_ok = a_min[MASK_BIT] | (a_min[TIME_W-1:0] == cur_min_i);
  assign a_hr_ok  = a_hour[MASK_BIT] | (a_hour[TIME_W-1:0] == cur_hour_i);

  // selector high: weekday, low: month day
  assign a_dd_eq = a_dd[DYDT_BIT] ?
                   (a_dd[DD_W-1:0] == {3'h0, cur_day_i}) :
                   (a_dd[DD_W-1:0] == cur_date_i);
  assign a_dd_ok = a_dd[MASK_BIT] | a_dd_eq;

  // unlisted mask patterns fall out of the
  // per-field form rather than being trapped
  assign a_match = a_sec_ok & a_min_ok & a_hr_ok & a_dd_ok;
  assign a_set   = sec_tick_i & a_match;

  // ----------------------------------------------------------------
  // alarm b compare
  // ----------------------------------------------------------------
  assign b_min  = alm_mem[IDX_B_MIN];
  assign b_hour = alm_mem[IDX_B_HOUR];
  assign b_dd   = alm_mem[IDX_B_DD];

  // alarm b has no seconds field; it fires on the 00 update
  assign sec_zero = (cur_sec_i == SEC_ZERO);
  assign b_min_ok = b_min[MASK_BIT] | (b_min[TIME_W-1:0] == cur_min_i);
  assign b_hr_ok  = b_hour[MASK_BIT] | (b_hour[TIME_W-1:0] == cur_hour_i);

  assign b_dd_eq = b_dd[DYDT_BIT] ?
                   (b_dd[DD_W-1:0] == {3'h0, cur_day_i}) :
                   (b_dd[DD_W-1:0] == cur_date_i);
  assign b_dd_ok = b_dd[MASK_BIT] | b_dd_eq;

  assign b_match = sec_zero & b_min_ok & b_hr_ok & b_dd_ok;
  assign b_set   = sec_tick_i & b_match;

  // ----------------------------------------------------------------
  // alarm flags
  // ----------------------------------------------------------------
  // 0 clears, 1 leaves the flag; a match on the clear
  // cycle wins so no alarm is lost
  assign fa_clr  = st_wr & ~reg_wdata_i[FLAG_A_BIT];
  assign fb_clr  = st_wr & ~reg_wdata_i[FLAG_B_BIT];
  assign fa_next = a_set | (fa_reg & ~fa_clr);
  assign fb_next = b_set | (fb_reg & ~fb_clr);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      fa_reg <= 1'b0;
      fb_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      fa_reg <= fa_next;
      fb_reg <= fb_next;
    end
  end

  // ----------------------------------------------------------------
  // interrupt and square-wave routing
  // ----------------------------------------------------------------
  // pin a: alarm a, or alarm b when not routed away
  assign irq_a_act = (fa_reg & a_en) | (fb_reg & b_en & ~route);
  assign irq_b_act = fb_reg & b_en & route;

  // the fastest rate is the raw oscillator, which
  // goes quiet when stopped
  assign osc_wave = ws2_reg[WV_OSC] & ~osc_en_n;

  assign wave_sel = (rate == RATE_1HZ) ? ws2_reg[WV_1HZ] :
                    (rate == RATE_4K)  ? ws2_reg[WV_4K]  :
                    (rate == RATE_8K)  ? ws2_reg[WV_8K]  :
                    osc_wave;

  // routing low gives the wave; high gives alarm b, active low
  assign pin_b_next = route ? ~irq_b_act : wave_sel;

  // ----------------------------------------------------------------
  // pin and read-data flops
  // ----------------------------------------------------------------
  // pins are open drain: drive only while pulling low
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_a_n_reg  <= 1'b1;
      irq_a_oe_reg <= 1'b0;
      pin_b_reg    <= 1'b1;
      pin_b_oe_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_a_n_reg  <= ~irq_a_act;
      irq_a_oe_reg <= irq_a_act;
      pin_b_reg    <= pin_b_next;
      pin_b_oe_reg <= ~pin_b_next;
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_reg <= 8'h00;
    else if (ce_i && reg_rd_i)
      rdata_reg <= rd_mux;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o         = rdata_reg;
  assign osc_enable_n_o      = ctl_reg[CTL_OSC_N_BIT];
  assign irq_out_a_n_o       = irq_a_n_reg;
  assign irq_out_a_oe_o      = irq_a_oe_reg;
  assign wave_or_irq_b_out_o = pin_b_reg;
  assign wave_or_irq_b_oe_o  = pin_b_oe_reg;

endmodule

// ===== include/rtc_pkg.sv
// constants and types of the rtc alarm and control block
package rtc_pkg;

  // ----------------------------------------------------------------
  // oscillator and square-wave divider
  // ----------------------------------------------------------------
  localparam int unsigned OSC_HZ     = 32768;
  localparam int unsigned WAVE_4K_HZ = 4096;
  localparam int unsigned WAVE_8K_HZ = 8192;
  localparam int unsigned WAVE_DIV_W = $clog2(OSC_HZ);
  localparam int unsigned BIT_1HZ    = WAVE_DIV_W - 1;
  localparam int unsigned BIT_4K     = $clog2(OSC_HZ / WAVE_4K_HZ) - 1;
  localparam int unsigned BIT_8K     = $clog2(OSC_HZ / WAVE_8K_HZ) - 1;

  // tap positions in the crossed wave vector
  localparam int unsigned WV_1HZ = 0;
  localparam int unsigned WV_4K  = 1;
  localparam int unsigned WV_8K  = 2;
  localparam int unsigned WV_OSC = 3;
  localparam int unsigned WV_W   = 4;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_A_SEC  = 5'h07;
  localparam logic [4:0] ADDR_B_DD   = 5'h0d;
  localparam logic [4:0] ADDR_CTRL   = 5'h0e;
  localparam logic [4:0] ADDR_STATUS = 5'h0f;

  // alarm storage entries, index = offset - ADDR_A_SEC
  localparam int unsigned ALARM_CNT = 7;
  localparam logic [2:0] IDX_A_SEC  = 3'h0;
  localparam logic [2:0] IDX_A_MIN  = 3'h1;
  localparam logic [2:0] IDX_A_HOUR = 3'h2;
  localparam logic [2:0] IDX_A_DD   = 3'h3;
  localparam logic [2:0] IDX_B_MIN  = 3'h4;
  localparam logic [2:0] IDX_B_HOUR = 3'h5;
  localparam logic [2:0] IDX_B_DD   = 3'h6;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int unsigned MASK_BIT = 7;
  localparam int unsigned DYDT_BIT = 6;
  localparam int unsigned TIME_W   = 7;
  localparam int unsigned DD_W     = 6;
  localparam int unsigned DAY_W    = 3;
  localparam int unsigned CTL_OSC_N_BIT = 7;
  localparam int unsigned CTL_RS_HI_BIT = 4;
  localparam int unsigned CTL_RS_LO_BIT = 3;
  localparam int unsigned CTL_ROUTE_BIT = 2;
  localparam int unsigned CTL_B_EN_BIT  = 1;
  localparam int unsigned CTL_A_EN_BIT  = 0;
  localparam logic [7:0] CTL_RESET = 8'h18;
  localparam logic [7:0] CTL_WMASK = 8'h9f;
  localparam int unsigned FLAG_A_BIT = 0;
  localparam int unsigned FLAG_B_BIT = 1;
  localparam logic [6:0] SEC_ZERO = 7'h00;

  // square-wave rate codes
  typedef enum logic [1:0] {RATE_1HZ, RATE_4K, RATE_8K, RATE_32K} rtc_rate_t;

endpackage

// ===== include/rtc_wave_if.sv
// carrier between register domain and oscillator divider
`timescale 1ns/10ps
interface rtc_wave_if;
  logic       run;    // oscillator allowed to run, register domain
  logic       freeze; // clock enable low, register domain
  logic [2:0] wave;   // divider taps, oscillator domain

  modport ctl (output run, output freeze, input wave);
  modport gen (input run, input freeze, output wave);
endinterface

// ===== rtl/rtc_wave_gen.sv
// oscillator-domain divider that makes the square-wave taps
`timescale 1ns/10ps
module rtc_wave_gen
  import rtc_pkg::*;
(
  input  wire logic osc_clk_i, // oscillator clock
  input  wire logic rst_n_i,   // register-domain reset, synced here
  rtc_wave_if.gen   wif        // taps out, run and freeze in
);

  // ----------------------------------------------------------------
  // synchronisers into the oscillator domain
  // ----------------------------------------------------------------
  logic                  rst_s1_reg; // reset, first stage
  logic                  rst_s2_reg; // reset, usable
  logic                  run_s1_reg; // run, first stage
  logic                  run_s2_reg; // run, usable
  logic                  frz_s1_reg; // freeze, first stage
  logic                  frz_s2_reg; // freeze, usable
  logic [WAVE_DIV_W-1:0] div_reg;    // free divider
  logic [WAVE_DIV_W-1:0] div_next;   // divider plus one
  logic                  div_step;   // divider advances

  // reset crosses by two flops into this domain
  always_ff @(posedge osc_clk_i)
  begin
    rst_s1_reg <= rst_n_i;
    rst_s2_reg <= rst_s1_reg;
  end

  // level crossings for run and freeze
  always_ff @(posedge osc_clk_i)
  begin
    if (!rst_s2_reg)
    begin
      run_s1_reg <= 1'b0;
      run_s2_reg <= 1'b0;
      frz_s1_reg <= 1'b0;
      frz_s2_reg <= 1'b0;
    end
    else
    begin
      run_s1_reg <= wif.run;
      run_s2_reg <= run_s1_reg;
      frz_s1_reg <= wif.freeze;
      frz_s2_reg <= frz_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  assign div_step = run_s2_reg & ~frz_s2_reg;
  assign div_next = div_reg + WAVE_DIV_W'(1);

  // a stopped oscillator holds every tap
  always_ff @(posedge osc_clk_i)
  begin
    if (!rst_s2_reg)
      div_reg <= '0;
    else if (div_step)
      div_reg <= div_next;
  end

  assign wif.wave = {div_reg[BIT_8K], div_reg[BIT_4K], div_reg[BIT_1HZ]};

endmodule

// ===== verification/rtc_alarm_ctrl_chk.sv
// port assertions for the rtc alarm and control block
`timescale 1ns/10ps
module rtc_alarm_ctrl_chk
  import rtc_pkg::*;
(
  input wire logic       clk_i,               // register clock
  input wire logic       rst_n_i,             // sync reset, low
  input wire logic       ce_i,                // clock enable
  input wire logic       sec_tick_i,          // second update
  input wire logic       reg_wr_i,            // write strobe
  input wire logic       reg_rd_i,            // read strobe
  input wire logic [4:0] reg_addr_i,          // offset
  input wire logic [7:0] reg_wdata_i,         // write data
  input wire logic [7:0] reg_rdata_o,         // read data
  input wire logic       osc_enable_n_o,      // oscillator stop
  input wire logic       irq_out_a_n_o,       // first pin
  input wire logic       irq_out_a_oe_o,      // first pin drive
  input wire logic       wave_or_irq_b_out_o, // shared pin
  input wire logic       wave_or_irq_b_oe_o   // shared pin drive
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  wire ctl_wr = reg_wr_i && ce_i && (reg_addr_i == ADDR_CTRL); // control write taken
  wire any_wr = reg_wr_i && ce_i;                              // any write taken

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // pins, control and read-back
  // ----------------------------------------------------------------
  // drive must mirror the low level, or the wire floats
  pin_a_drive_a: assert property (irq_out_a_oe_o == !irq_out_a_n_o)
    else $error("pin a drive wrong");
  pin_b_drive_a: assert property (wave_or_irq_b_oe_o == !wave_or_irq_b_out_o)
    else $error("pin b drive wrong");
  // pin a falls two cycles after a tick or a control write
  irq_fall_cause_a: assert property ($fell(irq_out_a_n_o) |->
    $past(sec_tick_i, 2) || $past(ctl_wr, 2)) else $error("pin a fell alone");
  // a level: only a write two cycles back releases it
  irq_rise_cause_a: assert property ($rose(irq_out_a_n_o) |-> $past(any_wr, 2))
    else $error("pin a rose alone");
  osc_bit_write_a: assert property (ctl_wr |=> osc_enable_n_o == $past(reg_wdata_i[7]))
    else $error("stop bit not written");
  osc_bit_hold_a: assert property (!ctl_wr |=> $stable(osc_enable_n_o))
    else $error("stop bit moved");
  reset_pins_a: assert property ($rose(rst_n_i) |->
    irq_out_a_n_o && !osc_enable_n_o && wave_or_irq_b_out_o) else $error("bad reset pins");
  ctl_read_zero_a: assert property (reg_rd_i && ce_i && reg_addr_i == ADDR_CTRL
    |=> reg_rdata_o[6:5] == 2'b00) else $error("control spares set");
  stat_read_zero_a: assert property (reg_rd_i && ce_i && reg_addr_i == ADDR_STATUS
    |=> reg_rdata_o[7:2] == 6'h00) else $error("status spares set");
endmodule

bind rtc_alarm_ctrl rtc_alarm_ctrl_chk chk (.clk_i, .rst_n_i, .ce_i, .sec_tick_i, .reg_wr_i,
  .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .osc_enable_n_o, .irq_out_a_n_o,
  .irq_out_a_oe_o, .wave_or_irq_b_out_o, .wave_or_irq_b_oe_o);

// ===== verification/rtc_host_model.sv
// host model making byte register accesses to the rtc block
`timescale 1ns/10ps
module rtc_host_model
(
  input  wire logic       clk_i,       // register clock
  input  wire logic [7:0] reg_rdata_i, // read data from block
  output logic            reg_wr_o    = 1'b0,  // write strobe
  output logic            reg_rd_o    = 1'b0,  // read strobe
  output logic      [4:0] reg_addr_o  = 5'h1f, // offset
  output logic      [7:0] reg_wdata_o = 8'h00  // write data
);
  // ----------------------------------------------------------------
  // one-cycle strobes launched off the falling edge
  // ----------------------------------------------------------------
  // idle bus shows the inverse, never a stale value
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = v;
    reg_wr_o    = 1'b1;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~v;
  endtask

  // registered data is settled one falling edge later
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge clk_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    v          = reg_rdata_i;
  endtask
endmodule

// ===== verification/testbench.sv
// self-checking bench for the rtc alarm and control block
`timescale 1ns/10ps
module testbench;
  import rtc_pkg::*;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic       clk_i      = 1'b0;  // register clock, 50 ns
  logic       osc_clk_i  = 1'b0;  // oscillator clock, 30 ns
  logic       rst_n_i    = 1'b0;  // sync reset
  logic       ce_i       = 1'b1;  // clock enable
  logic       sec_tick_i = 1'b0;  // second update
  logic [6:0] cur_sec_i  = 7'h00; // current seconds
  logic [6:0] cur_min_i  = 7'h00; // current minutes
  logic [6:0] cur_hour_i = 7'h00; // current hours
  logic [2:0] cur_day_i  = 3'h1;  // current weekday
  logic [5:0] cur_date_i = 6'h01; // current month day
  logic       reg_wr_i, reg_rd_i, osc_enable_n_o;      // strobes, stop
  logic [4:0] reg_addr_i;                              // offset
  logic [7:0] reg_wdata_i, reg_rdata_o, d;             // data
  logic       irq_out_a_n_o, irq_out_a_oe_o;           // first pin
  logic       wave_or_irq_b_out_o, wave_or_irq_b_oe_o; // shared pin
  int         err_count = 0, checks_done = 0, cycles = 0, n;
  int         mode[2] = '{4, 4};           // first masked field index
  int         val[2][4];                   // stored alarm fields
  bit         dydt[2];                     // weekday selector
  int         lo[4] = '{0, 70, 125, 50};   // toggles in 200 cycles
  int         hi[4] = '{1, 95, 200, 200};  // for a 30 ns oscillator

  always #25 clk_i = ~clk_i;
  // offset keeps the phases unrelated
  initial #7 forever #15 osc_clk_i = ~osc_clk_i;

  rtc_alarm_ctrl uut (.clk_i, .rst_n_i, .ce_i, .osc_clk_i, .sec_tick_i, .cur_sec_i,
    .cur_min_i, .cur_hour_i, .cur_day_i, .cur_date_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .osc_enable_n_o, .irq_out_a_n_o, .irq_out_a_oe_o,
    .wave_or_irq_b_out_o, .wave_or_irq_b_oe_o);
  rtc_host_model host (.clk_i, .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));

  // ----------------------------------------------------------------
  // reference model and helpers
  // ----------------------------------------------------------------
  // and over unmasked fields; alarm b also needs seconds 00
  function automatic bit hit(int al);
    int cur[4];
    bit ok;
    cur = '{cur_sec_i, cur_min_i, cur_hour_i, dydt[al] ? int'(cur_day_i) : int'(cur_date_i)};
    ok = (al == 0) || (cur_sec_i == 0);
    for (int k = al; k < 4; k++)
      ok &= (k >= mode[al]) || (cur[k] == val[al][k]);
    return ok;
  endfunction

  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // shared pin changes, after a gap for the sync
  task automatic count_toggles();
    logic prev;
    repeat (10) @(negedge clk_i);
    n = 0;
    prev = wave_or_irq_b_out_o;
    repeat (200)
    begin
      @(negedge clk_i);
      if (wave_or_irq_b_out_o !== prev) n++;
      prev = wave_or_irq_b_out_o;
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // run needs under two thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] ctl;
    logic       h0, h1;
    void'($urandom(99477));
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    host.rd(ADDR_CTRL, d);
    check("ctrl_reset", d, 8'h18);
    check("irq_a_idle", irq_out_a_n_o, 1'b1);
    host.wr(5'h03, 8'hff);
    host.rd(5'h03, d);
    check("unmapped", d, 8'h00);
    host.wr(ADDR_CTRL, 8'hff);
    host.rd(ADDR_CTRL, d);
    check("ctrl_wr", d, 8'h9f);
    // all mask modes, at most one field missed at random
    for (int al = 0; al < 2; al++)
      for (int m = al; m < 5; m++)
        repeat (3)
        begin
          mode[al] = m;
          dydt[al] = 1'($urandom_range(1));
          for (int k = al; k < 4; k++)
          begin
            val[al][k] = $urandom_range((k < 3) ? 127 : (dydt[al] ? 7 : 63));
            d = 8'(val[al][k]);
            if (k == 3) d[6] = dydt[al];
            d[7] = (k >= m);
            host.wr(5'((al ? 10 : 7) + k), d);
          end
          ctl = 8'h18 | 8'($urandom_range(7));
          host.wr(ADDR_CTRL, ctl);
          host.wr(ADDR_STATUS, 8'h00);
          cur_sec_i  = al ? 7'h00 : 7'(val[0][0]);
          cur_min_i  = 7'(val[al][1]);
          cur_hour_i = 7'(val[al][2]);
          cur_day_i  = 3'(val[al][3]);
          cur_date_i = 6'(val[al][3]);
          case ($urandom_range(4))
            0: cur_sec_i[0] = ~cur_sec_i[0];
            1: cur_min_i[0] = ~cur_min_i[0];
            2: cur_hour_i[0] = ~cur_hour_i[0];
            3: {cur_day_i[0], cur_date_i[0]} = ~{cur_day_i[0], cur_date_i[0]};
            default: ;
          endcase
          h0 = hit(0);
          h1 = hit(1);
          host.rd(ADDR_STATUS, d);
          check("no_tick", d, 8'h00);
          sec_tick_i = 1'b1;
          @(negedge clk_i);
          sec_tick_i = 1'b0;
          repeat (2) @(negedge clk_i);
          check("irq_a", irq_out_a_n_o, !(h0 & ctl[0] | h1 & ctl[1] & !ctl[2]));
          if (ctl[2]) check("irq_b", wave_or_irq_b_out_o, !(h1 & ctl[1]));
          host.wr(ADDR_STATUS, 8'h03);
          host.rd(ADDR_STATUS, d);
          check("flags", d, {6'h00, h1, h0});
          host.wr(ADDR_STATUS, 8'h00);
          repeat (3) @(negedge clk_i);
          check("irq_a_clr", irq_out_a_n_o, 1'b1);
        end
    // wave rates on routing 0, then oscillator stopped
    for (int r = 0; r < 4; r++)
    begin
      host.wr(ADDR_CTRL, 8'(r << 3));
      count_toggles();
      check("rate", 8'(n >= lo[r] && n <= hi[r]), 8'h01);
    end
    host.wr(ADDR_CTRL, 8'h88);
    count_toggles();
    check("stopped", 8'(n), 8'h00);
    check("osc_stop", osc_enable_n_o, 1'b1);
    finish_test();
  end
endmodule
